// ==== logic/geip_gpio_edge_pld.sv ====
// Top of the GPIO edge sensing, interrupt flag and small logic block
//
// Notes on behaviour
// - Two sense bits per I/O, I/O3 at top
// - Sense 00 none, 01 rise, 10 fall, 11 both
// - Matching edge sets the event flag
// - Unmasked edge also sets the interrupt flag
// - Write one to interrupt flag clears both flags
// - Interrupt pin low while any interrupt flag set
// - Write one to event flag clears both flags
// - Changing a sense field clears that I/O's flags
// - Mode 00 plain GPIO, mode 11 no function
// - Mode 01 drives I/O2 from first table
// - Mode 10 drives I/O3 from third table
// - First table bit n for I/O1:0 equal n
// - First table only matters in mode 01
// - Mask zero enables, one blocks, resets to ones
// - Third table bit n for I/O2:0 equal n
`timescale 1ns/1ns
`default_nettype none
module geip_gpio_edge_pld #(
  parameter logic [6:0] DEV_ADDR = 7'h2A // Arbitrary bus address
) (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic [3:0] gpio_in,
  output logic [3:0] gpio_out,
  output logic [3:0] gpio_oe_out,
  output logic irq_out_n_out
);
  localparam int N = geip_pkg::IO_W;
  localparam int SW = geip_pkg::SENSE_W;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Edge match for one I/O against its sense field
  function automatic logic edge_hit(input logic [1:0] cfg, input logic now,
                                    input logic was);
    edge_hit = (cfg[geip_pkg::SENSE_RISE] & now & ~was) |
               (cfg[geip_pkg::SENSE_FALL] & ~now & was);
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  geip_pkg::geip_wr_t wr; // Write strobe from serial slave
  logic [7:0] ptr; // Current register pointer
  logic [7:0] rdata; // Read mux output
  logic [7:0] mask_reg, mask_next; // irq_mask_bits
  logic [7:0] sense_reg, sense_next; // edge_sense_config
  logic [N-1:0] src_reg, src_next; // irq_source_flags
  logic [N-1:0] evt_reg, evt_next; // edge_event_flags
  logic [1:0] mode_reg, mode_next; // logic_mode_field
  logic [3:0] tab0_reg, tab0_next; // two_input_truth_table
  logic [7:0] tab2_reg, tab2_next; // three_input_truth_table
  logic [N-1:0] io_s1_reg, io_s2_reg, io_prev_reg; // Input synchroniser and history
  logic [N-1:0] hit; // Edges seen this cycle
  logic [N-1:0] clr; // Flags cleared this cycle
  logic irq_n_reg, irq_n_next; // Interrupt pin level
  logic [3:0] pin_reg, pin_next; // Logic outputs
  logic [3:0] pin_oe_reg, pin_oe_next; // Logic output enables
  logic sda_zero_reg; // Open-drain low level

  // ----------------------------------------
  // Serial register access
  // ----------------------------------------
  geip_i2c_slave #(
    .DEV_ADDR(DEV_ADDR)
  ) u_slave (
    .clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_oe_out(sda_oe_out),
    .rdata_in(rdata),
    .ptr_out(ptr),
    .wr_out(wr)
  );

  // Read mux; reserved bits and unmapped offsets read zero
  always_comb begin
    unique case (ptr)
      geip_pkg::ADDR_MASK: rdata = mask_reg;
      geip_pkg::ADDR_SENSE: rdata = sense_reg;
      geip_pkg::ADDR_SRC: rdata = {4'h0, src_reg};
      geip_pkg::ADDR_EVT: rdata = {4'h0, evt_reg};
      geip_pkg::ADDR_MODE: rdata = {6'h00, mode_reg};
      geip_pkg::ADDR_TAB0: rdata = {4'h0, tab0_reg};
      geip_pkg::ADDR_TAB2: rdata = tab2_reg;
      default: rdata = 8'h00;
    endcase
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  // Upper bits of narrow registers are dropped; the host keeps them zero
  always_comb begin
    mask_next = mask_reg;
    sense_next = sense_reg;
    mode_next = mode_reg;
    tab0_next = tab0_reg;
    tab2_next = tab2_reg;
    if (wr.valid) begin
      unique case (wr.addr)
        geip_pkg::ADDR_MASK: mask_next = wr.data;
        geip_pkg::ADDR_SENSE: sense_next = wr.data;
        geip_pkg::ADDR_MODE: mode_next = wr.data[1:0];
        geip_pkg::ADDR_TAB0: tab0_next = wr.data[3:0];
        geip_pkg::ADDR_TAB2: tab2_next = wr.data;
        default: begin
          // Flag registers and unmapped offsets store nothing here
        end
      endcase
    end
  end

  // ----------------------------------------
  // Edge detection and flags
  // ----------------------------------------
  always_comb begin
    clr = '0;
    for (int i = 0; i < N; i++) begin
      hit[i] = edge_hit(sense_reg[SW*i +: SW], io_s2_reg[i], io_prev_reg[i]);
      // A changed sense field drops stale flags of that I/O
      if (wr.valid && wr.addr == geip_pkg::ADDR_SENSE &&
          wr.data[SW*i +: SW] != sense_reg[SW*i +: SW]) begin
        clr[i] = 1'b1;
      end
    end
    // Either flag register clears both flags on a one
    if (wr.valid && (wr.addr == geip_pkg::ADDR_SRC || wr.addr == geip_pkg::ADDR_EVT)) begin
      clr = clr | wr.data[N-1:0];
    end
    // Set after clear, so an edge in the clearing cycle survives
    evt_next = (evt_reg & ~clr) | hit;
    src_next = (src_reg & ~clr) | (hit & ~mask_reg[N-1:0]);
    irq_n_next = ~|src_next;
  end

  // ----------------------------------------
  // Logic decode outputs
  // ----------------------------------------
  // Decode follows the synchronised pins, so a pin that drives its own
  // selector sees its own output two cycles later
  always_comb begin
    pin_next = 4'h0;
    pin_oe_next = 4'h0;
    unique case (mode_reg)
      geip_pkg::MODE_GPIO, geip_pkg::MODE_NONE: begin
        // No pin is taken over by the decode logic
      end
      geip_pkg::MODE_DEC2: begin
        pin_oe_next[geip_pkg::DEC2_PIN] = 1'b1;
        pin_next[geip_pkg::DEC2_PIN] = tab0_reg[io_s2_reg[1:0]];
      end
      geip_pkg::MODE_DEC3: begin
        pin_oe_next[geip_pkg::DEC3_PIN] = 1'b1;
        pin_next[geip_pkg::DEC3_PIN] = tab2_reg[io_s2_reg[2:0]];
      end
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mask_reg <= geip_pkg::RST_MASK;
      sense_reg <= geip_pkg::RST_SENSE;
      src_reg <= geip_pkg::RST_FLAGS;
      evt_reg <= geip_pkg::RST_FLAGS;
      mode_reg <= geip_pkg::RST_MODE;
      tab0_reg <= geip_pkg::RST_TAB0;
      tab2_reg <= geip_pkg::RST_TAB2;
      irq_n_reg <= 1'b1;
      io_s1_reg <= '0;
      io_s2_reg <= '0;
      io_prev_reg <= '0;
      pin_reg <= 4'h0;
      pin_oe_reg <= 4'h0;
      sda_zero_reg <= 1'b0;
    end else begin
      mask_reg <= mask_next;
      sense_reg <= sense_next;
      src_reg <= src_next;
      evt_reg <= evt_next;
      mode_reg <= mode_next;
      tab0_reg <= tab0_next;
      tab2_reg <= tab2_next;
      irq_n_reg <= irq_n_next;
      io_s1_reg <= gpio_in;
      io_s2_reg <= io_s1_reg;
      io_prev_reg <= io_s2_reg;
      pin_reg <= pin_next;
      pin_oe_reg <= pin_oe_next;
      sda_zero_reg <= 1'b0;
    end
  end

  assign gpio_out = pin_reg;
  assign gpio_oe_out = pin_oe_reg;
  assign irq_out_n_out = irq_n_reg;
  assign sda_out = sda_zero_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!nrst_in);

  chk_rise_sets_evt: assert property (
    (sense_reg[1:0] == 2'h1 && io_s2_reg[0] && !io_prev_reg[0]) |=> evt_reg[0])
    else $error("rising edge on io0 did not set event flag");

  chk_none_quiet: assert property (
    (sense_reg[7:6] == 2'h0 && !evt_reg[3]) |=> !evt_reg[3])
    else $error("event flag set with sense none");

  chk_mask_blocks: assert property (
    (mask_reg[1] && !src_reg[1]) |=> !src_reg[1])
    else $error("masked io set interrupt flag");

  chk_w1c_src: assert property (
    (wr.valid && wr.addr == geip_pkg::ADDR_SRC && wr.data[0] && !hit[0])
    |=> !src_reg[0] && !evt_reg[0])
    else $error("write one to interrupt flag did not clear both");

  chk_w1c_evt: assert property (
    (wr.valid && wr.addr == geip_pkg::ADDR_EVT && wr.data[2] && !hit[2])
    |=> !evt_reg[2] && !src_reg[2])
    else $error("write one to event flag did not clear both");

  chk_irq_pin: assert property (
    irq_out_n_out == !(|src_reg))
    else $error("interrupt pin disagrees with interrupt flags");

  chk_sense_clear: assert property (
    (wr.valid && wr.addr == geip_pkg::ADDR_SENSE && !hit[3] &&
     wr.data[7:6] != sense_reg[7:6]) |=> !evt_reg[3] && !src_reg[3])
    else $error("sense change did not clear flags");

  chk_set_wins: assert property (
    (wr.valid && (wr.addr == geip_pkg::ADDR_SRC || wr.addr == geip_pkg::ADDR_EVT) &&
     |(wr.data[N-1:0] & hit)) |=> &(evt_reg | ~$past(hit)))
    else $error("edge lost against clear");

  chk_set_wins_src: assert property (
    (wr.valid && (wr.addr == geip_pkg::ADDR_SRC || wr.addr == geip_pkg::ADDR_EVT) &&
     |(wr.data[N-1:0] & hit)) |=> &(src_reg | ~($past(hit) & ~$past(mask_reg[N-1:0]))))
    else $error("unmasked edge lost against clear");

  chk_dec2_out: assert property (
    (mode_reg == geip_pkg::MODE_DEC2 && io_s2_reg[1:0] == 2'h3 && tab0_reg[3])
    |=> gpio_out[2] && gpio_oe_out[2])
    else $error("two input decode wrong");

  chk_dec3_out: assert property (
    (mode_reg == geip_pkg::MODE_DEC3 && io_s2_reg[2:0] == 3'h0 && !tab2_reg[0])
    |=> !gpio_out[3] && gpio_oe_out[3])
    else $error("three input decode wrong");

  chk_gpio_idle: assert property (
    (mode_reg == geip_pkg::MODE_GPIO || mode_reg == geip_pkg::MODE_NONE)
    |=> gpio_oe_out == 4'h0)
    else $error("decode drove a pin outside decode modes");

  chk_unmask_sets: assert property (
    (hit[1] && !mask_reg[1]) |=> src_reg[1])
    else $error("unmasked edge did not set interrupt flag");

  chk_sense_store: assert property (
    (wr.valid && wr.addr == geip_pkg::ADDR_SENSE) |=> sense_reg == $past(wr.data))
    else $error("sense write not stored");

  chk_dec2_only: assert property (
    (mode_reg == geip_pkg::MODE_DEC2) |=> gpio_oe_out == (4'h1 << geip_pkg::DEC2_PIN))
    else $error("two input mode drove the wrong pins");

  chk_dec3_only: assert property (
    (mode_reg == geip_pkg::MODE_DEC3) |=> gpio_oe_out == (4'h1 << geip_pkg::DEC3_PIN))
    else $error("three input mode drove the wrong pins");

  chk_flags_hold: assert property (
    !wr.valid |=> ((evt_reg & $past(evt_reg)) == $past(evt_reg)) &&
    ((src_reg & $past(src_reg)) == $past(src_reg)))
    else $error("flag dropped without a clear");

  cov_irq_low: cover property (!irq_out_n_out ##[1:50] irq_out_n_out);
  cov_dec2: cover property (mode_reg == geip_pkg::MODE_DEC2 && gpio_out[2]);
  cov_dec3: cover property (mode_reg == geip_pkg::MODE_DEC3 && gpio_out[3]);
  cov_set_wins: cover property (wr.valid && wr.addr == geip_pkg::ADDR_SRC && |(wr.data[3:0] & hit));
  cov_sense_clear: cover property (wr.valid && wr.addr == geip_pkg::ADDR_SENSE && |evt_reg);
endmodule
`default_nettype wire

// ==== logic/geip_pkg.sv ====
// Shared constants and types for the GPIO edge, interrupt and logic block
package geip_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_MASK = 8'h05;
  localparam logic [7:0] ADDR_SENSE_HI = 8'h06;
  localparam logic [7:0] ADDR_SENSE = 8'h07;
  localparam logic [7:0] ADDR_SRC = 8'h08;
  localparam logic [7:0] ADDR_EVT = 8'h09;
  localparam logic [7:0] ADDR_MODE = 8'h10;
  localparam logic [7:0] ADDR_TAB0 = 8'h11;
  localparam logic [7:0] ADDR_TAB2 = 8'h13;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_MASK = 8'hFF;
  localparam logic [7:0] RST_SENSE = 8'h00;
  localparam logic [3:0] RST_FLAGS = 4'h0;
  localparam logic [1:0] RST_MODE = 2'h0;
  localparam logic [3:0] RST_TAB0 = 4'h0;
  localparam logic [7:0] RST_TAB2 = 8'h00;

  // ----------------------------------------
  // Field layout and encodings
  // ----------------------------------------
  localparam int IO_W = 4;
  localparam int SENSE_W = 2;
  localparam int SENSE_RISE = 0;
  localparam int SENSE_FALL = 1;
  localparam logic [1:0] MODE_GPIO = 2'h0;
  localparam logic [1:0] MODE_DEC2 = 2'h1;
  localparam logic [1:0] MODE_DEC3 = 2'h2;
  localparam logic [1:0] MODE_NONE = 2'h3;
  localparam int DEC2_PIN = 2;
  localparam int DEC3_PIN = 3;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  // Register write strobe from the serial slave
  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } geip_wr_t;
endpackage

// ==== logic/geip_i2c_slave.sv ====
// Two-wire serial slave giving byte-wide register access with auto-increment
`timescale 1ns/1ns
`default_nettype none
module geip_i2c_slave #(
  parameter logic [6:0] DEV_ADDR = 7'h2A // Arbitrary bus address
) (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe_out,
  input wire logic [7:0] rdata_in,
  output logic [7:0] ptr_out,
  output geip_pkg::geip_wr_t wr_out
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_DEV, ST_DEVACK, ST_PTR, ST_PTRACK, ST_WR, ST_WRACK, ST_RD, ST_RDACK
  } geip_i2c_st_t;

  // ----------------------------------------
  // State
  // ----------------------------------------
  geip_i2c_st_t st_reg, st_next; // Transfer phase
  logic scl_reg, sda_reg, scl_p_reg, sda_p_reg; // Line samples, current and previous
  logic [3:0] cnt_reg, cnt_next; // Bit count in byte
  logic [7:0] sh_reg, sh_next; // Shift register
  logic [7:0] ptr_reg, ptr_next; // Register pointer
  logic oe_reg, oe_next; // Pull data line low
  logic rw_reg, rw_next; // Read transfer
  logic ack_reg, ack_next; // Master acked last read byte
  geip_pkg::geip_wr_t wr_reg, wr_next;
  logic rise, fall, start, stop;

  // Line events; start and stop take priority over data bits
  assign rise = scl_reg & ~scl_p_reg;
  assign fall = ~scl_reg & scl_p_reg;
  assign start = scl_reg & scl_p_reg & sda_p_reg & ~sda_reg;
  assign stop = scl_reg & scl_p_reg & ~sda_p_reg & sda_reg;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    sh_next = sh_reg;
    ptr_next = ptr_reg;
    oe_next = oe_reg;
    rw_next = rw_reg;
    ack_next = ack_reg;
    wr_next = '0;
    if (stop) begin
      st_next = ST_IDLE;
      oe_next = 1'b0;
    end else if (start) begin
      // Repeated start keeps the pointer
      st_next = ST_DEV;
      cnt_next = 4'h0;
      oe_next = 1'b0;
    end else begin
      unique case (st_reg)
        ST_IDLE: begin
        end
        ST_DEV, ST_PTR, ST_WR: begin
          if (rise) begin
            sh_next = {sh_reg[6:0], sda_reg};
            cnt_next = cnt_reg + 4'h1;
          end else if (fall && cnt_reg == geip_pkg::BYTE_BITS) begin
            cnt_next = 4'h0;
            oe_next = 1'b1;
            if (st_reg == ST_DEV) begin
              // Other addresses: stay off the bus until next start
              if (sh_reg[7:1] == DEV_ADDR) begin
                rw_next = sh_reg[0];
                st_next = ST_DEVACK;
              end else begin
                oe_next = 1'b0;
                st_next = ST_IDLE;
              end
            end else if (st_reg == ST_PTR) begin
              ptr_next = sh_reg;
              st_next = ST_PTRACK;
            end else begin
              wr_next = '{valid: 1'b1, addr: ptr_reg, data: sh_reg};
              st_next = ST_WRACK;
            end
          end
        end
        ST_DEVACK: begin
          if (fall) begin
            if (rw_reg) begin
              sh_next = rdata_in;
              oe_next = ~rdata_in[7];
              st_next = ST_RD;
            end else begin
              oe_next = 1'b0;
              st_next = ST_PTR;
            end
          end
        end
        ST_PTRACK: begin
          if (fall) begin
            oe_next = 1'b0;
            st_next = ST_WR;
          end
        end
        ST_WRACK: begin
          if (fall) begin
            oe_next = 1'b0;
            ptr_next = ptr_reg + 8'h01;
            st_next = ST_WR;
          end
        end
        ST_RD: begin
          if (fall) begin
            if (cnt_reg == 4'h7) begin
              oe_next = 1'b0;
              ptr_next = ptr_reg + 8'h01;
              cnt_next = 4'h0;
              st_next = ST_RDACK;
            end else begin
              sh_next = {sh_reg[6:0], 1'b0};
              oe_next = ~sh_reg[6];
              cnt_next = cnt_reg + 4'h1;
            end
          end
        end
        ST_RDACK: begin
          if (rise) begin
            ack_next = ~sda_reg;
          end else if (fall) begin
            // Pointer already moved on, so the next byte is fetched here
            if (ack_reg) begin
              sh_next = rdata_in;
              oe_next = ~rdata_in[7];
              st_next = ST_RD;
            end else begin
              st_next = ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_reg <= ST_IDLE;
      {scl_reg, sda_reg, scl_p_reg, sda_p_reg} <= 4'hF;
      cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      ptr_reg <= 8'h00;
      oe_reg <= 1'b0;
      rw_reg <= 1'b0;
      ack_reg <= 1'b0;
      wr_reg <= '0;
    end else begin
      st_reg <= st_next;
      {scl_reg, sda_reg} <= {scl_in, sda_in};
      {scl_p_reg, sda_p_reg} <= {scl_reg, sda_reg};
      cnt_reg <= cnt_next;
      sh_reg <= sh_next;
      ptr_reg <= ptr_next;
      oe_reg <= oe_next;
      rw_reg <= rw_next;
      ack_reg <= ack_next;
      wr_reg <= wr_next;
    end
  end

  assign sda_oe_out = oe_reg;
  assign ptr_out = ptr_reg;
  assign wr_out = wr_reg;
endmodule
`default_nettype wire

// ==== sim/geip_host_model.sv ====
// Host controller model driving the two-wire register bus
`timescale 1ns/1ns
`default_nettype none
module geip_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h2A // Arbitrary bus address, matches the device default
) (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  // ----------------------------------------
  // Bus timing
  // ----------------------------------------
  localparam int PHASE = 4; // Clocks per scl phase, above the three the slave needs

  // Lines idle high; the model drives scl high and the pull-up holds the data line high outside frames
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end

  // Wait n clocks, then step just past the edge so changes never race sampling
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  // One bit slot; a 1 releases the line so the slave may answer in it
  task automatic put_bit(input logic b, output logic got);
    sda_low_out = ~b;
    tick(PHASE);
    scl_out = 1'b1;
    tick(PHASE);
    got = sda_in;
    scl_out = 1'b0;
    tick(1);
  endtask

  // ----------------------------------------
  // Frame pieces
  // ----------------------------------------
  // Eight bits MSB first, then a released ninth slot; for reads that slot is our nack
  task automatic put_byte(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i], g);
      q[i] = g;
    end
    put_bit(1'b1, g);
    ack = ~g;
  endtask

  // Start or repeated start: data falls while the clock is high
  task automatic start_cond();
    sda_low_out = 1'b0;
    tick(PHASE);
    scl_out = 1'b1;
    tick(PHASE);
    sda_low_out = 1'b1;
    tick(PHASE);
    scl_out = 1'b0;
    tick(1);
  endtask

  // Stop: data rises while the clock is high, then both lines left released
  task automatic stop_cond();
    sda_low_out = 1'b1;
    tick(PHASE);
    scl_out = 1'b1;
    tick(PHASE);
    sda_low_out = 1'b0;
    tick(PHASE);
  endtask

  // ----------------------------------------
  // Register access
  // ----------------------------------------
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data, output logic ok);
    logic [7:0] q;
    logic a0, a1, a2;
    start_cond();
    put_byte({DEV_ADDR, 1'b0}, q, a0);
    put_byte(addr, q, a1);
    put_byte(data, q, a2);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask

  // Pointer set by a write phase, then a repeated start reads one byte and nacks
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    logic [7:0] q;
    logic a0, a1, a2, a3;
    start_cond();
    put_byte({DEV_ADDR, 1'b0}, q, a0);
    put_byte(addr, q, a1);
    start_cond();
    put_byte({DEV_ADDR, 1'b1}, q, a2);
    put_byte(8'hFF, data, a3);
    stop_cond();
    ok = a0 & a1 & a2;
  endtask
endmodule
`default_nettype wire

// ==== sim/geip_gpio_edge_pld_tb_top.sv ====
// Self-checking bench for the GPIO edge, interrupt and logic block
`timescale 1ns/1ns
`default_nettype none
module geip_gpio_edge_pld_tb_top;
  // ----------------------------------------
  // Clock, reset and wires
  // ----------------------------------------
  logic clk_sys_in = 1'b0;
  logic nrst_in = 1'b0;
  logic scl, host_low, sda_wire, sda_out, sda_oe, irq_n; // Bus lines and interrupt pin
  logic [3:0] gpio_drv = 4'h0; // Level the outside world puts on undriven pins
  logic [3:0] gpio_pin, gpio_out, gpio_oe;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;

  always #4 clk_sys_in = ~clk_sys_in;

  // Open-drain data line with pull-up; a pin the block drives wins over the outside
  assign sda_wire = host_low ? 1'b0 : (sda_oe ? sda_out : 1'b1);
  assign gpio_pin = (gpio_oe & gpio_out) | (~gpio_oe & gpio_drv);

  geip_gpio_edge_pld dut_u (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .scl_in(scl),
    .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_out(sda_oe), .gpio_in(gpio_pin),
    .gpio_out(gpio_out), .gpio_oe_out(gpio_oe), .irq_out_n_out(irq_n));

  geip_host_model host_u (.clk_in(clk_sys_in), .sda_in(sda_wire), .scl_out(scl),
    .sda_low_out(host_low));

  // ----------------------------------------
  // Checking helpers
  // ----------------------------------------
  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("[FAIL] %0t ns: %s got %h expected %h", $time, what, got, exp);
      errors++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    host_u.write_reg(a, d, ok);
    chk("write ack", {7'h00, ok}, 8'h01);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic ok;
    logic [7:0] q;
    host_u.read_reg(a, q, ok);
    chk("read ack", {7'h00, ok}, 8'h01);
    chk("read data", q, exp);
  endtask

  // Let pin changes pass the synchronisers and reach the flags
  task automatic settle(input logic [3:0] v);
    gpio_drv = v;
    host_u.tick(6);
  endtask

  // Hang guard: full run needs about 14000 clocks
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      $display("[FAIL] %0t ns: run did not finish", $time);
      end_sim();
    end
  end

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    logic [7:0] addrs [7] = '{8'h05, 8'h07, 8'h08, 8'h09, 8'h10, 8'h11, 8'h13};
    logic [7:0] resets [7] = '{8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    repeat (6) @(posedge clk_sys_in);
    #1;
    nrst_in = 1'b1;
    host_u.tick(3);
    chk("irq after reset", {7'h00, irq_n}, 8'h01);
    foreach (addrs[i]) rd(addrs[i], resets[i]);
    rd(8'h20, 8'h00);
    // Distinct code per I/O: io3 both, io2 fall, io1 rise, io0 none
    wr(8'h07, 8'hE4);
    rd(8'h07, 8'hE4);
    wr(8'h06, 8'h55);
    rd(8'h07, 8'hE4);
    wr(8'h10, 8'h03);
    rd(8'h10, 8'h03);
    chk("mode 11 drives", {4'h0, gpio_oe}, 8'h00);
    wr(8'h10, 8'h00);
    // Mask all ones: events flag but never raise an interrupt
    settle(4'hF);
    rd(8'h09, 8'h0A);
    rd(8'h08, 8'h00);
    chk("irq masked", {7'h00, irq_n}, 8'h01);
    wr(8'h09, 8'h0F);
    rd(8'h09, 8'h00);
    settle(4'h0);
    rd(8'h09, 8'h0C);
    wr(8'h09, 8'h0F);
    // Unmask the low nibble and clear the two flags one by one
    wr(8'h05, 8'hF0);
    settle(4'hF);
    rd(8'h08, 8'h0A);
    rd(8'h09, 8'h0A);
    chk("irq raised", {7'h00, irq_n}, 8'h00);
    wr(8'h08, 8'h02);
    rd(8'h08, 8'h08);
    rd(8'h09, 8'h08);
    chk("irq held", {7'h00, irq_n}, 8'h00);
    wr(8'h09, 8'h08);
    rd(8'h08, 8'h00);
    chk("irq released", {7'h00, irq_n}, 8'h01);
    // Changing only io2's field drops io2's flags and keeps io3's
    settle(4'h0);
    rd(8'h08, 8'h0C);
    wr(8'h07, 8'hD4);
    rd(8'h09, 8'h08);
    rd(8'h08, 8'h08);
    wr(8'h09, 8'h0F);
    chk("irq cleared", {7'h00, irq_n}, 8'h01);
    // An io1 rise lands in the strobe cycle of the clearing write: 246 clocks
    // after the call the last data bit's clock falls, and the edge needs two
    settle(4'h2);
    settle(4'h0);
    fork
      wr(8'h08, 8'h02);
      begin
        host_u.tick(246);
        gpio_drv = 4'h2;
      end
    join
    rd(8'h09, 8'h02);
    rd(8'h08, 8'h02);
    wr(8'h08, 8'h02);
    // Decode modes walk every table index
    wr(8'h11, 8'h06);
    wr(8'h13, 8'h96);
    wr(8'h10, 8'h01);
    for (int n = 0; n < 4; n++) begin
      settle({2'h0, n[1:0]});
      chk("two-input enable", {4'h0, gpio_oe}, 8'h04);
      chk("two-input value", {7'h00, gpio_out[2]}, (8'h06 >> n) & 8'h01);
    end
    wr(8'h10, 8'h02);
    for (int n = 0; n < 8; n++) begin
      settle({1'h0, n[2:0]});
      chk("three-input enable", {4'h0, gpio_oe}, 8'h08);
      chk("three-input value", {7'h00, gpio_out[3]}, (8'h96 >> n) & 8'h01);
    end
    wr(8'h10, 8'h00);
    host_u.tick(4);
    chk("gpio mode drives", {4'h0, gpio_oe}, 8'h00);
    end_sim();
  end
endmodule
`default_nettype wire
